// file: core/ecc_device.sv
`timescale 1ns/1ps
module ecc_device import ecc_pkg::*; #(
    parameter int ADDR_W = ECC_ADDR_W,
    parameter int HALF_W = ECC_HALF_W
) (
    input wire logic mclk_i,
    input wire logic reset_i,
    ecc_link_if.device link,
    // Request from the core; taken when req_ready_o is high
    input wire logic req_valid_i,
    output logic req_ready_o,
    input wire logic [2:0] req_type_i,
    input wire logic [ADDR_W-1:0] req_addr_i,
    input wire logic [7:0] req_mask_i,
    input wire logic req_dstream_i,
    input wire logic [2*HALF_W-1:0] req_wdata_i,
    // Cycle completion
    output logic done_o,
    output logic [2:0] done_ack_o,
    output logic machine_check_o,
    output logic corrected_irq_o,
    output logic [2:0] err_type_o,
    output logic [ADDR_W-1:0] err_addr_o,
    output logic [2:0] err_ack_o,
    // Fill data out through a two-entry buffer
    output logic fill_valid_o,
    input wire logic fill_ready_i,
    output logic [HALF_W-1:0] fill_data_o,
    output logic fill_upper_o,
    output logic fill_check_o,
    output logic fill_cache_o,
    output logic fill_istream_ok_o,
    output logic fill_stall_o
);
    logic [2:0] req_reg, req_next;
    logic [ADDR_W-1:0] addr_reg;
    logic [7:0] mask_reg;
    logic [2*HALF_W-1:0] wdata_reg;
    logic half_cnt_reg;
    logic cache_en_reg;
    logic upper_lost_reg;
    logic drive_reg;
    logic drive_upper_reg;
    logic done_reg;
    logic [2:0] done_ack_reg;
    logic mcheck_reg, corr_reg;
    logic [2:0] err_type_reg, err_ack_reg;
    logic [ADDR_W-1:0] err_addr_reg;
    logic [HALF_W-1:0] bus_out_reg;
    logic istream_ok_reg;

    // Conditional store mask check: one longword or aligned quadword
    function automatic logic cond_mask_ok(input logic [7:0] m);
        cond_mask_ok = (m != 8'h00) && (((m & (m - 8'h01)) == 8'h00) ||
            m == 8'h03 || m == 8'h0c || m == 8'h30 || m == 8'hc0);
    endfunction : cond_mask_ok

    // Input decoding (same-clock synchronous inputs, no synchroniser)
    wire busy = (req_reg != ECC_REQ_IDLE);
    wire acked = busy && (link.cycle_ack != ECC_ACK_IDLE);
    wire rd_cycle = ecc_is_read(req_reg);
    wire wr_cycle = ecc_is_write(req_reg);
    wire rd_beat = rd_cycle && (link.read_data_code != ECC_RD_IDLE);
    wire buf_in_ready;
    wire req_legal = (req_type_i != ECC_REQ_COND_STORE) || cond_mask_ok(req_mask_i);
    wire take = req_valid_i && req_legal && (!busy || acked) && buf_in_ready;
    wire [7:0] mask_in = ecc_is_read(req_type_i) ?
        {5'h00, req_dstream_i, req_addr_i[4:3]} : req_mask_i;
    wire beat_check = link.read_data_code[ECC_RD_CHECK_BIT];
    wire beat_cache = half_cnt_reg ? cache_en_reg : link.read_data_code[ECC_RD_CACHE_BIT];
    wire want_upper = link.write_half_select[ECC_WSEL_HALF_BIT] || upper_lost_reg;

    assign req_ready_o = req_legal && (!busy || acked) && buf_in_ready;

    // Next cycle: new request, idle after acknowledge, or hold
    always_comb begin
        req_next = req_reg;
        if (take) begin
            req_next = req_type_i;
        end else if (acked) begin
            req_next = ECC_REQ_IDLE;
        end
    end

    // Cycle outputs, changed only on the clock edge
    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            req_reg <= ECC_REQ_IDLE;
            addr_reg <= '0;
            mask_reg <= ECC_MASK_RESET;
            wdata_reg <= '0;
        end else begin
            req_reg <= req_next;
            if (take) begin
                addr_reg <= req_addr_i;
                mask_reg <= mask_in;
                wdata_reg <= req_wdata_i;
            end
        end
    end

    // Fill half tracking and cache enable from first half
    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            half_cnt_reg <= 1'b0;
            cache_en_reg <= 1'b0;
            istream_ok_reg <= 1'b0;
        end else begin
            if (acked) begin
                half_cnt_reg <= 1'b0;
            end else if (rd_beat) begin
                half_cnt_reg <= ~half_cnt_reg;
            end
            if (rd_beat && !half_cnt_reg) begin
                cache_en_reg <= link.read_data_code[ECC_RD_CACHE_BIT];
            end
            // Instruction data usable on a non-fatal acknowledge with one half held or a half arriving
            istream_ok_reg <= acked && rd_cycle && (link.cycle_ack != ECC_ACK_FATAL) &&
                (half_cnt_reg || rd_beat) && !mask_reg[ECC_MASK_DSTREAM_BIT];
        end
    end

    // Write data drive control and half selection
    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            drive_reg <= 1'b0;
            drive_upper_reg <= 1'b0;
            upper_lost_reg <= 1'b0;
            bus_out_reg <= '0;
        end else begin
            drive_reg <= !link.data_drive_enable_n && (wr_cycle || ecc_is_write(req_next));
            drive_upper_reg <= want_upper;
            bus_out_reg <= want_upper ? wdata_reg[2*HALF_W-1:HALF_W] : wdata_reg[HALF_W-1:0];
            if (take && ecc_is_write(req_type_i)) begin
                bus_out_reg <= link.write_half_select[ECC_WSEL_HALF_BIT] ?
                    req_wdata_i[2*HALF_W-1:HALF_W] : req_wdata_i[HALF_W-1:0];
            end
            if (acked || !wr_cycle) begin
                upper_lost_reg <= 1'b0;
            end else if (link.write_half_select[ECC_WSEL_HALF_BIT]) begin
                upper_lost_reg <= 1'b1;
            end
        end
    end

    // Completion and error capture
    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            done_reg <= 1'b0;
            done_ack_reg <= ECC_ACK_IDLE;
            mcheck_reg <= 1'b0;
            corr_reg <= 1'b0;
            err_type_reg <= ECC_REQ_IDLE;
            err_ack_reg <= ECC_ACK_IDLE;
            err_addr_reg <= '0;
        end else begin
            done_reg <= acked;
            done_ack_reg <= acked ? link.cycle_ack : ECC_ACK_IDLE;
            mcheck_reg <= acked && (link.cycle_ack == ECC_ACK_FATAL);
            corr_reg <= acked && (link.cycle_ack == ECC_ACK_CORRECTED);
            if (acked && (link.cycle_ack == ECC_ACK_FATAL || link.cycle_ack == ECC_ACK_CORRECTED)) begin
                err_type_reg <= req_reg;
                err_ack_reg <= link.cycle_ack;
                err_addr_reg <= addr_reg;
            end
        end
    end

    // Two-entry buffer for fill halves: {upper, check, cache, data}
    logic [HALF_W+2:0] fifo_mem [2];
    logic rd_ptr_reg, wr_ptr_reg;
    logic [1:0] count_reg;
    wire fifo_push = rd_beat && (count_reg != 2'h2);
    wire fifo_pop = fill_valid_o && fill_ready_i;
    assign buf_in_ready = (count_reg == 2'h0);
    assign fill_valid_o = (count_reg != 2'h0);
    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            rd_ptr_reg <= 1'b0;
            wr_ptr_reg <= 1'b0;
            count_reg <= 2'h0;
        end else begin
            if (fifo_push) begin
                fifo_mem[wr_ptr_reg] <= {half_cnt_reg, beat_check, beat_cache, link.sys_data};
                wr_ptr_reg <= ~wr_ptr_reg;
            end
            if (fifo_pop) begin
                rd_ptr_reg <= ~rd_ptr_reg;
            end
            count_reg <= count_reg + {1'b0, fifo_push} - {1'b0, fifo_pop};
        end
    end

    // Outputs
    assign link.cycle_request = req_reg;
    assign link.address = addr_reg;
    assign link.longword_mask = mask_reg;
    assign link.dev_data = bus_out_reg;
    assign link.dev_data_oe = drive_reg;
    assign done_o = done_reg;
    assign done_ack_o = done_ack_reg;
    assign machine_check_o = mcheck_reg;
    assign corrected_irq_o = corr_reg;
    assign err_type_o = err_type_reg;
    assign err_addr_o = err_addr_reg;
    assign err_ack_o = err_ack_reg;
    assign fill_data_o = fill_valid_o ? fifo_mem[rd_ptr_reg][HALF_W-1:0] : '0;
    assign fill_upper_o = fill_valid_o && fifo_mem[rd_ptr_reg][HALF_W+2];
    assign fill_check_o = fill_valid_o && fifo_mem[rd_ptr_reg][HALF_W+1];
    assign fill_cache_o = fill_valid_o && fifo_mem[rd_ptr_reg][HALF_W];
    assign fill_istream_ok_o = istream_ok_reg;
    assign fill_stall_o = rd_beat && (count_reg == 2'h2);
endmodule : ecc_device

// file: core/ecc_pkg.sv
package ecc_pkg;
    // Cycle request codes
    localparam logic [2:0] ECC_REQ_IDLE = 3'h0;
    localparam logic [2:0] ECC_REQ_FENCE = 3'h1;
    localparam logic [2:0] ECC_REQ_PREFETCH = 3'h2;
    localparam logic [2:0] ECC_REQ_PREFETCH_MOD = 3'h3;
    localparam logic [2:0] ECC_REQ_FILL = 3'h4;
    localparam logic [2:0] ECC_REQ_WRITE = 3'h5;
    localparam logic [2:0] ECC_REQ_LOCKED_LOAD = 3'h6;
    localparam logic [2:0] ECC_REQ_COND_STORE = 3'h7;
    // Acknowledge codes
    localparam logic [2:0] ECC_ACK_IDLE = 3'h0;
    localparam logic [2:0] ECC_ACK_FATAL = 3'h1;
    localparam logic [2:0] ECC_ACK_CORRECTED = 3'h2;
    localparam logic [2:0] ECC_ACK_COND_FAIL = 3'h3;
    localparam logic [2:0] ECC_ACK_OK = 3'h4;
    // Read data codes
    localparam logic [2:0] ECC_RD_IDLE = 3'h0;
    localparam logic [2:0] ECC_RD_UNCACHED_UNCHECKED = 3'h4;
    localparam logic [2:0] ECC_RD_UNCACHED = 3'h5;
    localparam logic [2:0] ECC_RD_UNCHECKED = 3'h6;
    localparam logic [2:0] ECC_RD_CACHED_CHECKED = 3'h7;
    // Field positions
    localparam int ECC_RD_CHECK_BIT = 0;
    localparam int ECC_RD_CACHE_BIT = 1;
    localparam int ECC_MASK_DSTREAM_BIT = 2;
    localparam int ECC_WSEL_HALF_BIT = 1;
    // Widths and reset values
    localparam int ECC_ADDR_W = 34;
    localparam int ECC_HALF_W = 128;
    localparam logic [7:0] ECC_MASK_RESET = 8'h00;
    localparam logic [1:0] ECC_WSEL_RESET = 2'h0;

    // True when a cycle type reads a block
    function automatic logic ecc_is_read(input logic [2:0] req);
        ecc_is_read = (req == ECC_REQ_FILL) || (req == ECC_REQ_LOCKED_LOAD);
    endfunction : ecc_is_read

    // True when a cycle type writes a block
    function automatic logic ecc_is_write(input logic [2:0] req);
        ecc_is_write = (req == ECC_REQ_WRITE) || (req == ECC_REQ_COND_STORE);
    endfunction : ecc_is_write
endpackage : ecc_pkg

// file: core/ecc_link_if.sv
`timescale 1ns/1ps
interface ecc_link_if;
    import ecc_pkg::*;
    logic [2:0] cycle_request;
    logic [ECC_ADDR_W-1:0] address;
    logic [7:0] longword_mask;
    logic [2:0] cycle_ack;
    logic [2:0] read_data_code;
    logic data_drive_enable_n;
    logic [1:0] write_half_select;
    logic [ECC_HALF_W-1:0] dev_data;
    logic dev_data_oe;
    logic [ECC_HALF_W-1:0] sys_data;
    logic sys_data_oe;

    modport device (
        output cycle_request, address, longword_mask, dev_data, dev_data_oe,
        input cycle_ack, read_data_code, data_drive_enable_n, write_half_select, sys_data, sys_data_oe
    );
    modport system (
        input cycle_request, address, longword_mask, dev_data, dev_data_oe,
        output cycle_ack, read_data_code, data_drive_enable_n, write_half_select, sys_data, sys_data_oe
    );
endinterface : ecc_link_if

// file: core/ecc_system.sv
`timescale 1ns/1ps
module ecc_system import ecc_pkg::*; #(
    parameter int ADDR_W = ECC_ADDR_W,
    parameter int HALF_W = ECC_HALF_W
) (
    input wire logic mclk_i,
    input wire logic reset_i,
    ecc_link_if.system link,
    // Cycle seen by memory side; held until ack_valid_i with a legal code is accepted, a fence also waiting for wbuf_empty_i
    output logic cyc_valid_o,
    output logic [2:0] cyc_type_o,
    output logic [ADDR_W-1:0] cyc_addr_o,
    output logic [7:0] cyc_mask_o,
    input wire logic ack_valid_i,
    input wire logic [2:0] ack_code_i,
    input wire logic wbuf_empty_i,
    input wire logic cache_hit_i,
    // Fill data supply
    input wire logic rd_valid_i,
    input wire logic [2:0] rd_code_i,
    input wire logic [HALF_W-1:0] rd_data_i,
    input wire logic rd_garbage_i,
    // Write data pull
    input wire logic wr_enable_i,
    input wire logic wr_upper_i,
    output logic [HALF_W-1:0] wr_data_o,
    output logic [ADDR_W-1:0] locked_addr_o,
    output logic cache_check_o
);
    logic [2:0] ack_reg;
    logic [2:0] rd_code_reg;
    logic [HALF_W-1:0] rd_data_reg;
    logic oe_n_reg;
    logic [1:0] wsel_reg;
    logic [HALF_W-1:0] wr_data_reg;
    logic [ADDR_W-1:0] locked_addr_reg;
    logic cache_check_reg;

    // A cycle is pending while presented and not yet answered
    wire pending = (link.cycle_request != ECC_REQ_IDLE) && (ack_reg == ECC_ACK_IDLE);
    wire fence_ok = (link.cycle_request != ECC_REQ_FENCE) || wbuf_empty_i;
    wire code_ok = (ack_code_i inside {ECC_ACK_FATAL, ECC_ACK_CORRECTED, ECC_ACK_OK}) ||
        (ack_code_i == ECC_ACK_COND_FAIL && link.cycle_request == ECC_REQ_COND_STORE);
    wire ack_now = pending && ack_valid_i && fence_ok && code_ok;
    wire rd_now = pending && rd_valid_i && ecc_is_read(link.cycle_request);
    wire [2:0] rd_code = (rd_garbage_i || !rd_code_i[2]) ? ECC_RD_UNCACHED_UNCHECKED : rd_code_i;
    wire interlocked = (link.cycle_request == ECC_REQ_LOCKED_LOAD) ||
        (link.cycle_request == ECC_REQ_COND_STORE);

    // Acknowledge pulse, read code with data, write pull controls
    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            ack_reg <= ECC_ACK_IDLE;
            rd_code_reg <= ECC_RD_IDLE;
            rd_data_reg <= '0;
            oe_n_reg <= 1'b1;
            wsel_reg <= ECC_WSEL_RESET;
        end else begin
            ack_reg <= ack_now ? ack_code_i : ECC_ACK_IDLE;
            rd_code_reg <= rd_now ? rd_code : ECC_RD_IDLE;
            if (rd_now) begin
                rd_data_reg <= rd_data_i;
            end
            oe_n_reg <= !wr_enable_i;
            wsel_reg <= {wr_upper_i, 1'b0};
        end
    end

    // Write data capture, locked address and cache probe request
    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            wr_data_reg <= '0;
            locked_addr_reg <= '0;
            cache_check_reg <= 1'b0;
        end else begin
            if (link.dev_data_oe) begin
                wr_data_reg <= link.dev_data;
            end
            if (pending && link.cycle_request == ECC_REQ_LOCKED_LOAD) begin
                locked_addr_reg <= link.address;
            end
            cache_check_reg <= pending && interlocked && !cache_hit_i;
        end
    end

    // Outputs
    assign link.cycle_ack = ack_reg;
    assign link.read_data_code = rd_code_reg;
    assign link.sys_data = rd_data_reg;
    assign link.sys_data_oe = (rd_code_reg != ECC_RD_IDLE);
    assign link.data_drive_enable_n = oe_n_reg;
    assign link.write_half_select = wsel_reg;
    assign cyc_valid_o = pending;
    assign cyc_type_o = link.cycle_request;
    assign cyc_addr_o = link.address;
    assign cyc_mask_o = link.longword_mask;
    assign wr_data_o = wr_data_reg;
    assign locked_addr_o = locked_addr_reg;
    assign cache_check_o = cache_check_reg;
endmodule : ecc_system

// file: verification/ecc_link_properties.sv
`timescale 1ns/1ps
module ecc_link_properties import ecc_pkg::*; (
    input wire logic mclk_i,
    input wire logic reset_i,
    input wire logic [2:0] cycle_request,
    input wire logic [ECC_ADDR_W-1:0] address,
    input wire logic [7:0] longword_mask,
    input wire logic [2:0] cycle_ack,
    input wire logic [2:0] read_data_code,
    input wire logic data_drive_enable_n,
    input wire logic [1:0] write_half_select,
    input wire logic dev_data_oe
);
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (reset_i);
    // Cycle steps seen on the link
    sequence s_waiting;
        cycle_request != ECC_REQ_IDLE && cycle_ack == ECC_ACK_IDLE;
    endsequence
    sequence s_answered;
        cycle_request != ECC_REQ_IDLE && cycle_ack != ECC_ACK_IDLE;
    endsequence
    sequence s_read;
        cycle_request == ECC_REQ_FILL || cycle_request == ECC_REQ_LOCKED_LOAD;
    endsequence
    sequence s_write;
        cycle_request == ECC_REQ_WRITE || cycle_request == ECC_REQ_COND_STORE;
    endsequence
    // Request side
    chk_req_held_steady: assert property (s_waiting |=> $stable(cycle_request) && $stable(address))
        else $error("cycle changed before acknowledge");
    chk_mask_held_steady: assert property (s_waiting |=> $stable(longword_mask))
        else $error("mask changed before acknowledge");
    chk_done_cycle_gone: assert property (s_answered |=> cycle_request != $past(cycle_request)
        || address != $past(address))
        else $error("acknowledged cycle still presented");
    chk_read_mask_addr: assert property (s_read |-> longword_mask[1:0] == address[4:3])
        else $error("read mask does not carry quadword address");
    chk_stc_mask_shape: assert property (cycle_request == ECC_REQ_COND_STORE |-> $onehot(longword_mask)
        || longword_mask inside {8'h03, 8'h0c, 8'h30, 8'hc0})
        else $error("conditional store mask not a longword or quadword");
    // Answer side
    chk_ack_code_legal: assert property (cycle_ack inside {3'h0, 3'h1, 3'h2, 3'h3, 3'h4})
        else $error("illegal acknowledge code");
    chk_fail_only_stc: assert property (cycle_ack == ECC_ACK_COND_FAIL |-> cycle_request == ECC_REQ_COND_STORE)
        else $error("store fail acknowledge on other cycle");
    chk_rd_code_legal: assert property (read_data_code inside {3'h0, 3'h4, 3'h5, 3'h6, 3'h7})
        else $error("illegal read data code");
    chk_rd_code_reads: assert property (read_data_code != ECC_RD_IDLE |-> s_read)
        else $error("read data code outside a read cycle");
    // Data bus drive
    chk_bus_floats: assert property (data_drive_enable_n |=> !dev_data_oe)
        else $error("data bus driven while disabled");
    chk_bus_drives: assert property (!data_drive_enable_n && !write_half_select[0] ##0 s_write |=> dev_data_oe)
        else $error("write data not driven");
endmodule : ecc_link_properties

// file: verification/external_cycle_control_tb.sv
`timescale 1ns/1ps
module external_cycle_control_tb;
    import ecc_pkg::*;
    logic mclk_i = 1'b0;
    logic reset_i = 1'b1;
    logic req_valid_i = 1'b0, req_dstream_i = 1'b0, fill_ready_i = 1'b0, ack_valid_i = 1'b0, wbuf_empty_i = 1'b1;
    logic rd_valid_i = 1'b0, wr_enable_i = 1'b0, wr_upper_i = 1'b0, req_ready_o, done_o, machine_check_o, cyc_valid_o;
    logic corrected_irq_o, fill_valid_o, fill_upper_o, fill_check_o, fill_cache_o, fill_istream_ok_o;
    logic [2:0] req_type_i = 3'h0, ack_code_i = 3'h0, rd_code_i = 3'h0, done_ack_o, err_type_o, err_ack_o;
    logic [7:0] req_mask_i = 8'h00;
    logic [ECC_ADDR_W-1:0] req_addr_i = '0, err_addr_o, locked_addr_o;
    logic [ECC_HALF_W-1:0] rd_data_i = '0, fill_data_o, wr_data_o;
    logic [2*ECC_HALF_W-1:0] req_wdata_i = '0;
    int mismatches = 0;
    int compares = 0;
    int i;
    ecc_link_if ecc_link_if_inst ();
    ecc_device ecc_device_inst (.mclk_i, .reset_i, .link(ecc_link_if_inst), .req_valid_i, .req_ready_o, .req_type_i,
        .req_addr_i, .req_mask_i, .req_dstream_i, .req_wdata_i, .done_o, .done_ack_o, .machine_check_o,
        .corrected_irq_o, .err_type_o, .err_addr_o, .err_ack_o, .fill_valid_o, .fill_ready_i, .fill_data_o,
        .fill_upper_o, .fill_check_o, .fill_cache_o, .fill_istream_ok_o, .fill_stall_o());
    ecc_system ecc_system_inst (.mclk_i, .reset_i, .link(ecc_link_if_inst),
        .cyc_valid_o, .cyc_type_o(), .cyc_addr_o(), .cyc_mask_o(), .ack_valid_i, .ack_code_i, .wbuf_empty_i,
        .cache_hit_i(1'b0), .rd_valid_i, .rd_code_i, .rd_data_i, .rd_garbage_i(1'b0), .wr_enable_i, .wr_upper_i,
        .wr_data_o, .locked_addr_o, .cache_check_o());
    ecc_link_properties ecc_link_properties_inst (.mclk_i, .reset_i, .cycle_request(ecc_link_if_inst.cycle_request),
        .address(ecc_link_if_inst.address), .longword_mask(ecc_link_if_inst.longword_mask),
        .cycle_ack(ecc_link_if_inst.cycle_ack), .read_data_code(ecc_link_if_inst.read_data_code),
        .data_drive_enable_n(ecc_link_if_inst.data_drive_enable_n),
        .write_half_select(ecc_link_if_inst.write_half_select), .dev_data_oe(ecc_link_if_inst.dev_data_oe));
    // System clock
    initial begin
        forever #25 mclk_i = ~mclk_i;
    end
    task automatic check(input logic [127:0] got, input logic [127:0] exp, input string what);
        compares++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH at %0t: %s", $time, what);
        end
    endtask : check
    task automatic step();
        @(posedge mclk_i);
        #1;
    endtask : step
    // Bounded wait for a flag, then confirm it
    task automatic await(ref logic s, input string what);
        for (int k = 0; k < 30 && s !== 1'b1; k++) step();
        check(s, 1'b1, what);
    endtask : await
    // Post one cycle, held until the device takes it
    task automatic issue(input logic [2:0] t, input logic [ECC_ADDR_W-1:0] a, input logic [7:0] m, input logic d);
        req_type_i = t;
        req_addr_i = a;
        req_mask_i = m;
        req_dstream_i = d;
        req_valid_i = 1'b1;
        for (int k = 0; k < 30; k++) begin
            @(posedge mclk_i);
            if (req_ready_o === 1'b1) break;
        end
        #1;
        req_valid_i = 1'b0;
        await(cyc_valid_o, "cycle posted");
        check(ecc_link_if_inst.cycle_request, t, "cycle type");
    endtask : issue
    // Acknowledge, held until it shows on the link; any pending read half goes along
    task automatic ack(input logic [2:0] code);
        ack_code_i = code;
        ack_valid_i = 1'b1;
        for (int k = 0; k < 30; k++) begin
            step();
            rd_valid_i = 1'b0;
            if (ecc_link_if_inst.cycle_ack !== ECC_ACK_IDLE) break;
        end
        ack_valid_i = 1'b0;
        await(done_o, "cycle done");
        check(done_ack_o, code, "completion code");
    endtask : ack
    task automatic half(input logic [2:0] code, input logic [127:0] d);
        rd_code_i = code;
        rd_data_i = d;
        rd_valid_i = 1'b1;
    endtask : half
    // Check one buffered fill half while it stands, then let the ready edge pop it
    task automatic take(input logic up, input logic [127:0] d, input logic chk, input logic cch);
        for (int k = 0; k < 30 && fill_valid_o !== 1'b1; k++) step();
        check(fill_upper_o, up, "fill half order");
        check(fill_data_o, d, "fill data");
        check(fill_check_o, chk, "check enable");
        check(fill_cache_o, cch, "cache enable");
        step();
    endtask : take
    task automatic pull(input logic up, input logic [127:0] d);
        logic seen;
        seen = 1'b0;
        wr_upper_i = up;
        for (int k = 0; k < 8 && !seen; k++) begin
            step();
            seen = (wr_data_o === d);
        end
        check(seen, 1'b1, "write half data");
    endtask : pull
    task automatic results();
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : results
    // Main sequence
    initial begin
        repeat (12) @(posedge mclk_i);
        #1;
        reset_i = 1'b0;
        for (i = 0; i < 2; i++) begin
            issue(i ? ECC_REQ_LOCKED_LOAD : ECC_REQ_FILL, i ? 34'h2008 : 34'h1050, 8'h00, !i);
            check(ecc_link_if_inst.longword_mask[2:0], i ? 3'h1 : 3'h6, "read mask");
            half(i ? ECC_RD_UNCHECKED : ECC_RD_CACHED_CHECKED, 128'h1111);
            step();
            rd_valid_i = 1'b0;
            step();
            half(i ? ECC_RD_UNCACHED_UNCHECKED : ECC_RD_UNCACHED, 128'h2222);
            ack(ECC_ACK_OK);
            check(fill_istream_ok_o, i[0], "istream fill usable");
            fill_ready_i = 1'b1;
            take(1'b0, 128'h1111, !i, 1'b1);
            take(1'b1, 128'h2222, !i, 1'b1);
            step();
            fill_ready_i = 1'b0;
            $display("test read %0d done", i);
        end
        check(locked_addr_o, 34'h2008, "locked address");
        req_wdata_i = {128'hbbbb, 128'haaaa};
        issue(ECC_REQ_WRITE, 34'h3000, 8'ha5, 1'b0);
        check(ecc_link_if_inst.longword_mask, 8'ha5, "write mask");
        wr_enable_i = 1'b1;
        pull(1'b0, 128'haaaa);
        check(ecc_link_if_inst.dev_data_oe, 1'b1, "bus driven");
        pull(1'b1, 128'hbbbb);
        wr_enable_i = 1'b0;
        step();
        step();
        check(ecc_link_if_inst.dev_data_oe, 1'b0, "bus floated");
        ack(ECC_ACK_OK);
        issue(ECC_REQ_COND_STORE, 34'h4010, 8'h0c, 1'b0);
        check(ecc_link_if_inst.longword_mask, 8'h0c, "store mask");
        wr_upper_i = 1'b0;
        ack(ECC_ACK_COND_FAIL);
        $display("test write done");
        issue(ECC_REQ_FILL, 34'h5000, 8'h00, 1'b0);
        half(ECC_RD_CACHED_CHECKED, 128'h3333);
        ack(ECC_ACK_FATAL);
        await(machine_check_o, "machine check");
        check(err_type_o, ECC_REQ_FILL, "error type");
        check(err_addr_o, 34'h5000, "error address");
        check(err_ack_o, ECC_ACK_FATAL, "error code");
        check(fill_istream_ok_o, 1'b0, "partial istream fill unused");
        fill_ready_i = 1'b1;
        take(1'b0, 128'h3333, 1'b1, 1'b1);
        fill_ready_i = 1'b0;
        issue(ECC_REQ_PREFETCH, 34'h6000, 8'h00, 1'b0);
        ack(ECC_ACK_CORRECTED);
        await(corrected_irq_o, "corrected interrupt");
        check(err_type_o, ECC_REQ_PREFETCH, "corrected error type");
        $display("test errors done");
        wbuf_empty_i = 1'b0;
        issue(ECC_REQ_FENCE, 34'h7000, 8'h00, 1'b0);
        ack_code_i = ECC_ACK_OK;
        ack_valid_i = 1'b1;
        repeat (4) step();
        check(ecc_link_if_inst.cycle_ack, ECC_ACK_IDLE, "fence held while buffers busy");
        wbuf_empty_i = 1'b1;
        ack(ECC_ACK_OK);
        issue(ECC_REQ_PREFETCH_MOD, 34'h8000, 8'h00, 1'b0);
        ack(ECC_ACK_OK);
        $display("test hints done");
        results();
    end
    // Watchdog
    initial begin
        #1000000;
        mismatches++;
        results();
    end
endmodule : external_cycle_control_tb
